//--- common/supply_regs_pkg.sv
// Package for the buck3, backup supply and DDR reference register bank.
// Assumes an 8-bit register port with byte offsets and 8-bit data.
package supply_regs_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  localparam logic [7:0] OFS_BUCK3_STANDBY_VOLTAGE = 8'h3F;
  localparam logic [7:0] OFS_BUCK3_SLEEP_VOLTAGE = 8'h40;
  localparam logic [7:0] OFS_BUCK3_MODE_CONTROL = 8'h41;
  localparam logic [7:0] OFS_BUCK3_LIMIT_TIMING_CONTROL = 8'h42;
  localparam logic [7:0] OFS_BACKUP_SUPPLY_CONTROL = 8'h48;
  localparam logic [7:0] OFS_DDR_REFERENCE_CONTROL = 8'h4A;

  // Writable masks: unused positions read zero and ignore writes.
  localparam logic [7:0] MASK_BUCK3_VOLTAGE = 8'h0F;
  localparam logic [7:0] MASK_BUCK3_MODE = 8'hCF;
  localparam logic [7:0] MASK_BUCK3_LIMIT = 8'h13;
  localparam logic [7:0] MASK_BACKUP = 8'h3F;
  localparam logic [7:0] MASK_DDR_REF = 8'h0F;

  // Values held in reset before fuses are applied.
  localparam logic [7:0] RST_BUCK3_MODE = 8'h00;
  localparam logic [7:0] RST_BUCK3_LIMIT = 8'h00;
  localparam logic [7:0] RST_BACKUP = 8'h00;
  localparam logic [7:0] RST_DDR_REF = 8'h00;
  localparam logic [3:0] RST_VOLTAGE_CODE = 4'h0;
  localparam logic [7:0] RD_ZERO = 8'h00;

  typedef struct packed {
    logic [3:0] buck3_standby_voltage_code;
    logic [3:0] buck3_sleep_voltage_code;
    logic buck3_run_enable;
    logic buck3_standby_enable;
    logic [1:0] buck3_current_limit_select;
    logic ddr_ref_enable;
    logic ddr_ref_standby_enable;
  } fuse_preload_s;

  typedef struct packed {
    logic buck3_run_enable;
    logic buck3_standby_enable;
    logic buck3_sleep_enable;
    logic buck3_low_power_select;
    logic buck3_forced_pwm;
    logic buck3_discharge_disable;
    logic [1:0] buck3_current_limit_select;
    logic buck3_timing_control_select;
    logic [3:0] buck3_standby_voltage_code;
    logic [3:0] buck3_sleep_voltage_code;
  } buck3_ctrl_s;

  typedef struct packed {
    logic [2:0] backup_voltage_placeholder;
    logic backup_eval_bit;
    logic force_supply_selector;
    logic backup_bandgap_disable;
    logic ddr_ref_enable;
    logic ddr_ref_standby_on;
    logic ddr_ref_sleep_on;
    logic ddr_ref_low_power;
  } aux_ctrl_s;

  typedef enum logic [1:0] {
    LOAD_WAIT,
    LOAD_APPLY,
    LOAD_DONE
  } load_state_e;

endpackage : supply_regs_pkg

//--- hw/fuse_loader.sv
// Sequencer that applies fuse values once after reset release.
// Assumes fuse_valid rises once the fuse bank has been sensed.
`timescale 1ns/1ps
module fuse_loader
  import supply_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic fuse_valid,
  output logic load_pulse,
  output logic loaded
);

  load_state_e state_q, state_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      LOAD_WAIT: begin
        if (fuse_valid) begin
          state_d = LOAD_APPLY;
        end
      end
      LOAD_APPLY: state_d = LOAD_DONE;
      LOAD_DONE: state_d = LOAD_DONE;
      default: state_d = LOAD_WAIT;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= LOAD_WAIT;
    end else begin
      state_q <= state_d;
    end
  end

  // The load is a single pulse, so later software writes are never undone.
  assign load_pulse = (state_q == LOAD_APPLY);
  assign loaded = (state_q == LOAD_DONE);

endmodule : fuse_loader

//--- hw/supply_regs.sv
// Register bank for buck3, the backup supply and the DDR reference.
// Assumes a synchronous register port and a fuse bank with a valid flag.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
module supply_regs
  import supply_regs_pkg::*;
#(
  parameter int ADDR_WIDTH = ADDR_W,
  parameter int DATA_WIDTH = DATA_W
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [ADDR_WIDTH-1:0] reg_addr,
  input wire logic [DATA_WIDTH-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [DATA_WIDTH-1:0] reg_rdata,
  input wire logic fuse_valid,
  input wire fuse_preload_s fuse_in,
  output logic fuses_loaded,
  output buck3_ctrl_s buck3_ctrl,
  output aux_ctrl_s aux_ctrl
);

  // The decoder and masks are byte wide, so other widths are refused.
  if (ADDR_WIDTH != ADDR_W || DATA_WIDTH != DATA_W) begin : g_bad_width
    $error("supply_regs serves only 8-bit address and data");
  end

  logic load_pulse;
  logic loaded;

  fuse_loader u_loader (
    .clk(clk),
    .rstn(rstn),
    .fuse_valid(fuse_valid),
    .load_pulse(load_pulse),
    .loaded(loaded)
  );

  logic [3:0] stby_volt_q, stby_volt_d;
  logic [3:0] slp_volt_q, slp_volt_d;
  logic [7:0] mode_q, mode_d;
  logic [7:0] limit_q, limit_d;
  logic [7:0] backup_q, backup_d;
  logic [7:0] ddr_q, ddr_d;
  logic [7:0] rdata_q, rdata_d;
  logic loaded_q;
  buck3_ctrl_s buck3_q, buck3_d;
  aux_ctrl_s aux_q, aux_d;

  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [7:0] wr,
                                       input logic [7:0] mask);
    merge = (old & ~mask) | (wr & mask);
  endfunction : merge

  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  always_comb begin
    stby_volt_d = stby_volt_q;
    slp_volt_d = slp_volt_q;
    mode_d = mode_q;
    limit_d = limit_q;
    backup_d = backup_q;
    ddr_d = ddr_q;
    if (load_pulse) begin
      stby_volt_d = fuse_in.buck3_standby_voltage_code;
      slp_volt_d = fuse_in.buck3_sleep_voltage_code;
      mode_d[0] = fuse_in.buck3_run_enable;
      mode_d[1] = fuse_in.buck3_standby_enable;
      limit_d[1:0] = fuse_in.buck3_current_limit_select;
      ddr_d[0] = fuse_in.ddr_ref_enable;
      ddr_d[1] = fuse_in.ddr_ref_standby_enable;
    end else if (reg_write) begin
      // Voltage registers take no write: the regulator cannot scale live.
      if (hit(reg_addr, OFS_BUCK3_MODE_CONTROL)) begin
        mode_d = merge(mode_q, reg_wdata, MASK_BUCK3_MODE);
      end
      if (hit(reg_addr, OFS_BUCK3_LIMIT_TIMING_CONTROL)) begin
        limit_d = merge(limit_q, reg_wdata, MASK_BUCK3_LIMIT);
      end
      if (hit(reg_addr, OFS_BACKUP_SUPPLY_CONTROL)) begin
        backup_d = merge(backup_q, reg_wdata, MASK_BACKUP);
      end
      if (hit(reg_addr, OFS_DDR_REFERENCE_CONTROL)) begin
        ddr_d = merge(ddr_q, reg_wdata, MASK_DDR_REF);
      end
    end
  end

  always_comb begin
    rdata_d = RD_ZERO;
    if (reg_read) begin
      case (reg_addr)
        OFS_BUCK3_STANDBY_VOLTAGE: rdata_d = {4'h0, stby_volt_q};
        OFS_BUCK3_SLEEP_VOLTAGE: rdata_d = {4'h0, slp_volt_q};
        OFS_BUCK3_MODE_CONTROL: rdata_d = mode_q & MASK_BUCK3_MODE;
        OFS_BUCK3_LIMIT_TIMING_CONTROL: rdata_d = limit_q & MASK_BUCK3_LIMIT;
        OFS_BACKUP_SUPPLY_CONTROL: rdata_d = backup_q & MASK_BACKUP;
        OFS_DDR_REFERENCE_CONTROL: rdata_d = ddr_q & MASK_DDR_REF;
        default: rdata_d = RD_ZERO;
      endcase
    end
  end

  always_comb begin
    buck3_d.buck3_run_enable = mode_q[0];
    buck3_d.buck3_standby_enable = mode_q[1];
    buck3_d.buck3_sleep_enable = mode_q[2];
    buck3_d.buck3_low_power_select = mode_q[3];
    buck3_d.buck3_forced_pwm = mode_q[6];
    buck3_d.buck3_discharge_disable = mode_q[7];
    buck3_d.buck3_current_limit_select = limit_q[1:0];
    buck3_d.buck3_timing_control_select = limit_q[4];
    buck3_d.buck3_standby_voltage_code = stby_volt_q;
    buck3_d.buck3_sleep_voltage_code = slp_volt_q;
    aux_d.backup_voltage_placeholder = backup_q[2:0];
    aux_d.backup_eval_bit = backup_q[3];
    aux_d.force_supply_selector = backup_q[4];
    aux_d.backup_bandgap_disable = backup_q[5];
    aux_d.ddr_ref_enable = ddr_q[0];
    // Standby and sleep only count while the main enable is set.
    aux_d.ddr_ref_standby_on = ddr_q[1] & ddr_q[0];
    aux_d.ddr_ref_sleep_on = ddr_q[2] & ddr_q[0];
    aux_d.ddr_ref_low_power = ddr_q[3];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stby_volt_q <= RST_VOLTAGE_CODE;
      slp_volt_q <= RST_VOLTAGE_CODE;
      mode_q <= RST_BUCK3_MODE;
      limit_q <= RST_BUCK3_LIMIT;
      backup_q <= RST_BACKUP;
      ddr_q <= RST_DDR_REF;
      rdata_q <= RD_ZERO;
      loaded_q <= 1'b0;
      buck3_q <= '0;
      aux_q <= '0;
    end else begin
      stby_volt_q <= stby_volt_d;
      slp_volt_q <= slp_volt_d;
      mode_q <= mode_d;
      limit_q <= limit_d;
      backup_q <= backup_d;
      ddr_q <= ddr_d;
      rdata_q <= rdata_d;
      loaded_q <= loaded;
      buck3_q <= buck3_d;
      aux_q <= aux_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign fuses_loaded = loaded_q;
  assign buck3_ctrl = buck3_q;
  assign aux_ctrl = aux_q;

endmodule : supply_regs

//--- tb/supply_regs_sva.sv
// Checker for the supply register bank, seeing only its top ports.
// Assumes one clock and the active-low asynchronous reset.
`timescale 1ns/1ps
module supply_regs_sva
  import supply_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic fuses_loaded,
  input wire buck3_ctrl_s buck3_ctrl,
  input wire aux_ctrl_s aux_ctrl,
  input wire logic fuse_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_idle; !reg_read |=> reg_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("rdata not idle");
  property p_stby;
    reg_read && reg_addr == 8'h3F |=> reg_rdata[7:4] == 4'h0;
  endproperty
  a_stby: assert property (p_stby) else $error("0x3F high bits");
  property p_slp;
    reg_read && reg_addr == 8'h40 |=> reg_rdata[7:4] == 4'h0;
  endproperty
  a_slp: assert property (p_slp) else $error("0x40 high bits");
  property p_mode;
    reg_read && reg_addr == 8'h41 |=> reg_rdata[5:4] == 2'h0;
  endproperty
  a_mode: assert property (p_mode) else $error("0x41 unused bits");
  property p_lim;
    reg_read && reg_addr == 8'h42 |=> (reg_rdata & 8'hEC) == 8'h00;
  endproperty
  a_lim: assert property (p_lim) else $error("0x42 unused bits");
  property p_bak;
    reg_read && reg_addr == 8'h48 |=> reg_rdata[7:6] == 2'h0;
  endproperty
  a_bak: assert property (p_bak) else $error("0x48 unused bits");
  property p_ddr;
    reg_read && reg_addr == 8'h4A |=> reg_rdata[7:4] == 4'h0;
  endproperty
  a_ddr: assert property (p_ddr) else $error("0x4A unused bits");
  property p_dstby;
    aux_ctrl.ddr_ref_standby_on |-> aux_ctrl.ddr_ref_enable;
  endproperty
  a_dstby: assert property (p_dstby) else $error("standby ungated");
  property p_dslp; aux_ctrl.ddr_ref_sleep_on |-> aux_ctrl.ddr_ref_enable;
  endproperty
  a_dslp: assert property (p_dslp) else $error("sleep ungated");
  property p_b3;
    reg_write && reg_addr == 8'h41 && fuses_loaded |-> ##2
      {buck3_ctrl.buck3_forced_pwm, buck3_ctrl.buck3_sleep_enable} ==
      {$past(reg_wdata[6], 2), $past(reg_wdata[2], 2)};
  endproperty
  a_b3: assert property (p_b3) else $error("buck3 output lag");
  property p_keep; fuses_loaded |=> fuses_loaded; endproperty
  a_keep: assert property (p_keep) else $error("load flag dropped");
  property p_fload; $rose(fuses_loaded) |-> $past(fuse_valid, 3);
  endproperty
  a_fload: assert property (p_fload) else $error("load too early");
  property p_vcode;
    fuses_loaded && $past(fuses_loaded) |->
      $stable(buck3_ctrl.buck3_standby_voltage_code) &&
      $stable(buck3_ctrl.buck3_sleep_voltage_code);
  endproperty
  a_vcode: assert property (p_vcode) else $error("code changed");
endmodule : supply_regs_sva

bind supply_regs supply_regs_sva chk (.clk, .rstn, .reg_addr, .reg_wdata,
  .reg_write, .reg_read, .reg_rdata, .fuses_loaded, .buck3_ctrl, .aux_ctrl,
  .fuse_valid);

//--- tb/supply_regs_tb_top.sv
// Self-checking bench for the supply register bank.
// Assumes supply_regs with its fuse loader and the bound checker.
`timescale 1ns/1ps
module supply_regs_tb_top;
  import supply_regs_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic fuse_valid = 1'b0;
  fuse_preload_s fuse_in = '0;
  logic [7:0] reg_rdata;
  logic fuses_loaded;
  buck3_ctrl_s buck3_ctrl;
  aux_ctrl_s aux_ctrl;
  logic [7:0] model [0:255];
  logic [7:0] regs [0:6] = '{8'h3F, 8'h40, 8'h41, 8'h42, 8'h48, 8'h4A, 8'h43};
  logic [7:0] d;
  int fail_count = 0;
  int n_compared = 0;

  supply_regs dut (.clk, .rstn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .fuse_valid, .fuse_in, .fuses_loaded, .buck3_ctrl, .aux_ctrl);

  initial begin
    forever #5 clk = ~clk;
  end

  // Read-only and unmapped places get a zero mask, so writes leave them.
  function automatic logic [7:0] wmask(input logic [7:0] a);
    case (a)
      8'h41: return 8'hCF;
      8'h42: return 8'h13;
      8'h48: return 8'h3F;
      8'h4A: return 8'h0F;
      default: return 8'h00;
    endcase
  endfunction : wmask

  // Expected control outputs, rebuilt from the register model.
  function automatic buck3_ctrl_s exp_b3();
    return {model[8'h41][0], model[8'h41][1], model[8'h41][2],
            model[8'h41][3], model[8'h41][6], model[8'h41][7],
            model[8'h42][1:0], model[8'h42][4], model[8'h3F][3:0],
            model[8'h40][3:0]};
  endfunction : exp_b3

  // Standby and sleep of the reference only count with its main enable.
  function automatic aux_ctrl_s exp_aux();
    return {model[8'h48][2:0], model[8'h48][3], model[8'h48][4],
            model[8'h48][5], model[8'h4A][0],
            model[8'h4A][1] & model[8'h4A][0],
            model[8'h4A][2] & model[8'h4A][0], model[8'h4A][3]};
  endfunction : exp_aux

  task automatic cmp_b3(input buck3_ctrl_s exp, input buck3_ctrl_s got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD buck3_ctrl exp %h got %h", exp, got);
    end
  endtask : cmp_b3

  task automatic cmp_aux(input aux_ctrl_s exp, input aux_ctrl_s got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD aux_ctrl exp %h got %h", exp, got);
    end
  endtask : cmp_aux

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_write <= 1'b0;
    model[a] = (model[a] & ~wmask(a)) | (v & wmask(a));
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    check("rdata", model[a], reg_rdata);
  endtask : rd

  task automatic give_verdict;
    if (fail_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    give_verdict();
  end

  initial begin
    foreach (model[i]) model[i] = 8'h00;
    void'($urandom(93));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 7; i++) rd(regs[i]);
    @(posedge clk);
    fuse_in <= 14'($urandom);
    fuse_valid <= 1'b1;
    for (int i = 0; i < 20 && fuses_loaded !== 1'b1; i++) @(posedge clk);
    check("loaded", 8'h01, {7'h0, fuses_loaded});
    model[8'h3F] = {4'h0, fuse_in.buck3_standby_voltage_code};
    model[8'h40] = {4'h0, fuse_in.buck3_sleep_voltage_code};
    model[8'h41] = {6'h0, fuse_in.buck3_standby_enable,
                    fuse_in.buck3_run_enable};
    model[8'h42] = {6'h0, fuse_in.buck3_current_limit_select};
    model[8'h4A] = {6'h0, fuse_in.ddr_ref_standby_enable,
                    fuse_in.ddr_ref_enable};
    for (int i = 0; i < 7; i++) rd(regs[i]);
    cmp_b3(exp_b3(), buck3_ctrl);
    cmp_aux(exp_aux(), aux_ctrl);
    for (int i = 0; i < 7; i++) begin
      wr(regs[i], 8'hFF);
      rd(regs[i]);
      wr(regs[i], 8'h00);
      rd(regs[i]);
    end
    repeat (40) begin
      d = regs[$urandom_range(6)];
      wr(d, 8'($urandom));
      rd(d);
      cmp_b3(exp_b3(), buck3_ctrl);
      cmp_aux(exp_aux(), aux_ctrl);
    end
    repeat (8) begin
      d = 8'($urandom);
      wr(8'h41, d);
      wr(8'h4A, d);
      repeat (2) @(posedge clk);
      #1;
      check("b3", {5'h0, d[7], d[6], d[2]}, {5'h0,
        buck3_ctrl.buck3_discharge_disable, buck3_ctrl.buck3_forced_pwm,
        buck3_ctrl.buck3_sleep_enable});
      check("ddr", {5'h0, d[1] & d[0], d[2] & d[0], d[3]}, {5'h0,
        aux_ctrl.ddr_ref_standby_on, aux_ctrl.ddr_ref_sleep_on,
        aux_ctrl.ddr_ref_low_power});
    end
    give_verdict();
  end
endmodule : supply_regs_tb_top
